// [t8cu_clksel.v]
// timer tick source: prescaler taps or the external count pin
// assumes clk is the system clock; ext_pin is asynchronous
`include "t8cu_consts.vh"

module t8cu_clksel #(
  parameter PRE_W = 10
) (
  input wire clk,
  input wire reset_n,
  input wire enable,
  input wire [2:0] sel,
  input wire ext_pin,
  output reg tick
);

reg [PRE_W-1:0] pre_q;
reg ext_s1_q;
reg ext_s2_q;
reg ext_s3_q;
reg tick_d;

function low_ones;
  input [PRE_W-1:0] v;
  input integer n;
  integer i;
  begin
    low_ones = 1'b1;
    for (i = 0; i < PRE_W; i = i + 1) begin
      if (i < n && !v[i])
        low_ones = 1'b0;
    end
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// the pin is synchronised before any edge detection
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    ext_s1_q <= 1'b0;
    ext_s2_q <= 1'b0;
    ext_s3_q <= 1'b0;
    pre_q <= {PRE_W{1'b0}};
    tick <= 1'b0;
  end else begin
    ext_s1_q <= ext_pin;
    ext_s2_q <= ext_s1_q;
    ext_s3_q <= ext_s2_q;
    // the divider halts in power reduction to save toggling
    if (enable)
      pre_q <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
    tick <= tick_d;
  end
end

////////////////////////////////////////////////////////////////////////////
always @* begin
  tick_d = 1'b0;
  if (enable) begin
    case (sel)
      `T8CU_CS_OFF: tick_d = 1'b0;
      `T8CU_CS_DIV1: tick_d = 1'b1;
      `T8CU_CS_DIV8: tick_d = low_ones(pre_q, `T8CU_TAP_DIV8);
      `T8CU_CS_DIV64: tick_d = low_ones(pre_q, `T8CU_TAP_DIV64);
      `T8CU_CS_DIV256: tick_d = low_ones(pre_q, `T8CU_TAP_DIV256);
      `T8CU_CS_DIV1024: tick_d = low_ones(pre_q, `T8CU_TAP_DIV1024);
      `T8CU_CS_EXT_FALL: tick_d = ext_s3_q & ~ext_s2_q;
      `T8CU_CS_EXT_RISE: tick_d = ext_s2_q & ~ext_s3_q;
      default: tick_d = 1'b0;
    endcase
  end
end

endmodule

// [t8cu_consts.vh]
// constants for the 8-bit timer with two compare units
// definitions only; included by every design file of the block
`ifndef T8CU_CONSTS_VH
`define T8CU_CONSTS_VH

// register word indices, byte address is index times four
`define T8CU_REG_CTRL_A 4'h0
`define T8CU_REG_CTRL_B 4'h1
`define T8CU_REG_COUNT 4'h2
`define T8CU_REG_CMP_A 4'h3
`define T8CU_REG_CMP_B 4'h4
`define T8CU_REG_MASK 4'h5
`define T8CU_REG_FLAG 4'h6
`define T8CU_REG_POWER 4'h7

// control register a fields
`define T8CU_COM_A_HI 7
`define T8CU_COM_A_LO 6
`define T8CU_COM_B_HI 5
`define T8CU_COM_B_LO 4
`define T8CU_WGM_HI 1
`define T8CU_WGM_LO 0
`define T8CU_CTRL_A_MASK 8'hf3
// control register b fields
`define T8CU_FOC_A 7
`define T8CU_FOC_B 6
`define T8CU_WGM_TOP 3
`define T8CU_CS_HI 2
`define T8CU_CS_LO 0
`define T8CU_CTRL_B_MASK 8'h0f
// flag and mask bit positions
`define T8CU_BIT_OVF 0
`define T8CU_BIT_CMP_A 1
`define T8CU_BIT_CMP_B 2
`define T8CU_BIT_PWR 0

// count boundaries and reset values
`define T8CU_BOTTOM 8'h00
`define T8CU_MAX 8'hff
`define T8CU_RST_BYTE 8'h00
`define T8CU_RST_FLAGS 3'h0

// clock select codes
`define T8CU_CS_OFF 3'h0
`define T8CU_CS_DIV1 3'h1
`define T8CU_CS_DIV8 3'h2
`define T8CU_CS_DIV64 3'h3
`define T8CU_CS_DIV256 3'h4
`define T8CU_CS_DIV1024 3'h5
`define T8CU_CS_EXT_FALL 3'h6
`define T8CU_CS_EXT_RISE 3'h7
// prescaler taps, in bits of the divider
`define T8CU_TAP_DIV8 3
`define T8CU_TAP_DIV64 6
`define T8CU_TAP_DIV256 8
`define T8CU_TAP_DIV1024 10

// waveform mode codes
`define T8CU_WGM_NORMAL 3'h0
`define T8CU_WGM_PC_MAX 3'h1
`define T8CU_WGM_CTC 3'h2
`define T8CU_WGM_FAST_MAX 3'h3
`define T8CU_WGM_PC_OCRA 3'h5
`define T8CU_WGM_FAST_OCRA 3'h7

// compare output mode codes
`define T8CU_COM_NONE 2'h0
`define T8CU_COM_TOGGLE 2'h1
`define T8CU_COM_CLEAR 2'h2
`define T8CU_COM_SET 2'h3

`endif

// [t8cu_top.v]
// 8-bit timer/counter with two compare units behind an avalon slave
// assumes one system clock; acks come from logic on the same clock
//
// Notes on behaviour
// - count zero is the bottom indication
// - all-ones count signals maximum reached
// - top is max or compare a, per mode
// - tick from prescaler or external pin edge
// - clock select zero stops the counter
// - each tick clears, increments or decrements count
// - software count access anytime; write wins
// - mode field split over control a and b
// - overflow flag set per mode, can interrupt
// - both compare registers compared continuously
// - compare flag set one tick after match
// - flag cleared by service or writing one
// - three flags, each masked individually
// - compare registers buffered only in pwm modes
// - buffer copied at top only
// - buffered modes route software to the buffer
// - force strobe acts like match, non-pwm only
// - forced compare leaves flags and counter alone
// - power reduction bit one disables the timer
// - outputs from match, mode, output mode, boundaries
// - counter and compare registers are 8 bits
// - count write blocks matches for next tick
// - normal mode counts up and wraps
// - clear-on-match mode clears at compare a
`include "t8cu_consts.vh"

module t8cu_top #(
  parameter PRE_W = 10
) (
  input wire clk,
  input wire reset_n,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire external_count_pin,
  input wire overflow_ack,
  input wire compare_a_ack,
  input wire compare_b_ack,
  output wire irq_overflow,
  output wire irq_compare_a,
  output wire irq_compare_b,
  output wire compare_output_a,
  output wire compare_output_a_drive,
  output wire compare_output_b,
  output wire compare_output_b_drive
);

////////////////////////////////////////////////////////////////////////////
// state

reg wait_q;
reg [31:0] rdata_q;
reg [7:0] ctrl_a_q;
reg [7:0] ctrl_b_q;
reg [7:0] count_value_q;
reg [7:0] count_value_d;
reg down_q;
reg down_d;
reg block_q;
reg [7:0] compare_a_value_q;
reg [7:0] compare_b_value_q;
reg [7:0] buf_a_q;
reg [7:0] buf_b_q;
reg [2:0] mask_q;
reg [2:0] flag_q;
reg [2:0] flag_d;
reg [2:0] irq_q;
reg power_off_q;
reg ovf_set;
reg [7:0] rd_mux;

wire tick;

////////////////////////////////////////////////////////////////////////////
// bus decode; a request is taken at the edge where waitrequest is low

wire [3:0] idx = avs_address[5:2];
wire [7:0] wd = avs_writedata[7:0];
wire taken = (avs_read | avs_write) & ~wait_q;
wire wr = taken & avs_write & avs_byteenable[0];
wire wr_ctrl_a = wr && (idx == `T8CU_REG_CTRL_A);
wire wr_ctrl_b = wr && (idx == `T8CU_REG_CTRL_B);
wire wr_count = wr && (idx == `T8CU_REG_COUNT);
wire wr_cmp_a = wr && (idx == `T8CU_REG_CMP_A);
wire wr_cmp_b = wr && (idx == `T8CU_REG_CMP_B);
wire wr_mask = wr && (idx == `T8CU_REG_MASK);
wire wr_flag = wr && (idx == `T8CU_REG_FLAG);
wire wr_power = wr && (idx == `T8CU_REG_POWER);

////////////////////////////////////////////////////////////////////////////
// mode decode

wire [2:0] wgm = {ctrl_b_q[`T8CU_WGM_TOP],
  ctrl_a_q[`T8CU_WGM_HI:`T8CU_WGM_LO]};
wire [2:0] clk_sel = ctrl_b_q[`T8CU_CS_HI:`T8CU_CS_LO];
wire [1:0] com_a = ctrl_a_q[`T8CU_COM_A_HI:`T8CU_COM_A_LO];
wire [1:0] com_b = ctrl_a_q[`T8CU_COM_B_HI:`T8CU_COM_B_LO];
wire pwm_fast = (wgm == `T8CU_WGM_FAST_MAX) ||
  (wgm == `T8CU_WGM_FAST_OCRA);
wire pwm_pc = (wgm == `T8CU_WGM_PC_MAX) || (wgm == `T8CU_WGM_PC_OCRA);
wire pwm = pwm_fast | pwm_pc;
wire top_is_a = (wgm == `T8CU_WGM_CTC) || (wgm == `T8CU_WGM_PC_OCRA) ||
  (wgm == `T8CU_WGM_FAST_OCRA);
wire [7:0] top = top_is_a ? compare_a_value_q : `T8CU_MAX;

wire at_bottom = (count_value_q == `T8CU_BOTTOM);
wire at_max = (count_value_q == `T8CU_MAX);
wire at_top = (count_value_q == top);

// matches are suppressed for one tick after a count write
wire eq_a = (count_value_q == compare_a_value_q) & ~block_q;
wire eq_b = (count_value_q == compare_b_value_q) & ~block_q;
wire match_a = tick & eq_a;
wire match_b = tick & eq_b;

// force strobes are single-cycle and never stored
wire force_a = wr_ctrl_b & wd[`T8CU_FOC_A] & ~pwm;
wire force_b = wr_ctrl_b & wd[`T8CU_FOC_B] & ~pwm;

// buffered modes load the working copy once per period
wire cmp_update = pwm & tick & at_top;

////////////////////////////////////////////////////////////////////////////
// compare register next value, shared by both units

function [7:0] cmp_next;
  input [7:0] cur;
  input [7:0] buffered;
  input [7:0] data;
  input write;
  input buffering;
  input update;
  begin
    cmp_next = cur;
    if (write && !buffering)
      cmp_next = data;
    else if (buffering && update)
      cmp_next = buffered;
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// tick source

t8cu_clksel #(
  .PRE_W(PRE_W)
) u_clksel (
  .clk(clk),
  .reset_n(reset_n),
  .enable(~power_off_q),
  .sel(clk_sel),
  .ext_pin(external_count_pin),
  .tick(tick)
);

////////////////////////////////////////////////////////////////////////////
// counter unit

always @* begin
  count_value_d = count_value_q;
  down_d = pwm_pc & down_q; // direction holds between ticks, cleared outside phase correct
  ovf_set = 1'b0;
  if (tick) begin
    if (pwm_pc) begin
      down_d = down_q;
      if (!down_q) begin
        if (at_top) begin
          down_d = 1'b1;
          count_value_d = count_value_q - 8'h01;
        end else begin
          count_value_d = count_value_q + 8'h01;
        end
      end else begin
        if (at_bottom) begin
          down_d = 1'b0;
          count_value_d = count_value_q + 8'h01;
          ovf_set = 1'b1;
        end else begin
          count_value_d = count_value_q - 8'h01;
        end
      end
    end else if (pwm_fast) begin
      count_value_d = at_top ? `T8CU_BOTTOM : count_value_q + 8'h01;
      ovf_set = at_top;
    end else if (wgm == `T8CU_WGM_CTC) begin
      count_value_d = at_top ? `T8CU_BOTTOM : count_value_q + 8'h01;
      ovf_set = at_max;
    end else begin
      // other codes behave as plain upward counting
      count_value_d = count_value_q + 8'h01;
      ovf_set = at_max;
    end
  end
  // software write wins over any clear or count this cycle
  if (wr_count) begin
    count_value_d = wd;
    down_d = down_q;
  end
end

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    count_value_q <= `T8CU_RST_BYTE;
    down_q <= 1'b0;
    block_q <= 1'b0;
  end else begin
    count_value_q <= count_value_d;
    down_q <= down_d;
    if (wr_count)
      block_q <= 1'b1;
    else if (tick)
      block_q <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////
// compare registers and their buffers

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    compare_a_value_q <= `T8CU_RST_BYTE;
    compare_b_value_q <= `T8CU_RST_BYTE;
    buf_a_q <= `T8CU_RST_BYTE;
    buf_b_q <= `T8CU_RST_BYTE;
  end else begin
    if (wr_cmp_a)
      buf_a_q <= wd;
    if (wr_cmp_b)
      buf_b_q <= wd;
    compare_a_value_q <= cmp_next(compare_a_value_q, buf_a_q, wd,
      wr_cmp_a, pwm, cmp_update);
    compare_b_value_q <= cmp_next(compare_b_value_q, buf_b_q, wd,
      wr_cmp_b, pwm, cmp_update);
  end
end

////////////////////////////////////////////////////////////////////////////
// flags: hardware set wins over any clear in the same cycle

always @* begin
  flag_d = flag_q;
  if (wr_flag)
    flag_d = flag_d & ~wd[2:0];
  if (overflow_ack)
    flag_d[`T8CU_BIT_OVF] = 1'b0;
  if (compare_a_ack)
    flag_d[`T8CU_BIT_CMP_A] = 1'b0;
  if (compare_b_ack)
    flag_d[`T8CU_BIT_CMP_B] = 1'b0;
  // a forced compare never reaches this point
  if (ovf_set)
    flag_d[`T8CU_BIT_OVF] = 1'b1;
  if (match_a)
    flag_d[`T8CU_BIT_CMP_A] = 1'b1;
  if (match_b)
    flag_d[`T8CU_BIT_CMP_B] = 1'b1;
end

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    flag_q <= `T8CU_RST_FLAGS;
    mask_q <= `T8CU_RST_FLAGS;
    irq_q <= `T8CU_RST_FLAGS;
  end else begin
    flag_q <= flag_d;
    if (wr_mask)
      mask_q <= wd[2:0];
    irq_q <= flag_q & mask_q;
  end
end

////////////////////////////////////////////////////////////////////////////
// control registers

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    ctrl_a_q <= `T8CU_RST_BYTE;
    ctrl_b_q <= `T8CU_RST_BYTE;
    power_off_q <= 1'b0;
  end else begin
    if (wr_ctrl_a)
      ctrl_a_q <= wd & `T8CU_CTRL_A_MASK;
    if (wr_ctrl_b)
      ctrl_b_q <= wd & `T8CU_CTRL_B_MASK;
    if (wr_power)
      power_off_q <= wd[`T8CU_BIT_PWR];
  end
end

////////////////////////////////////////////////////////////////////////////
// waveform generators

t8cu_wave u_wave_a (
  .clk(clk),
  .reset_n(reset_n),
  .tick(tick),
  .match(match_a),
  .force_cmp(force_a),
  .pwm_fast(pwm_fast),
  .pwm_pc(pwm_pc),
  .down(down_q),
  .wrap(at_top),
  .tog_ok(top_is_a),
  .com(com_a),
  .oc(compare_output_a),
  .oc_drive(compare_output_a_drive)
);

// unit b has no toggle in pwm, its register never sets top
t8cu_wave u_wave_b (
  .clk(clk),
  .reset_n(reset_n),
  .tick(tick),
  .match(match_b),
  .force_cmp(force_b),
  .pwm_fast(pwm_fast),
  .pwm_pc(pwm_pc),
  .down(down_q),
  .wrap(at_top),
  .tog_ok(1'b0),
  .com(com_b),
  .oc(compare_output_b),
  .oc_drive(compare_output_b_drive)
);

////////////////////////////////////////////////////////////////////////////
// read mux; compare reads see the buffer while buffering

always @* begin
  case (idx)
    `T8CU_REG_CTRL_A: rd_mux = ctrl_a_q;
    `T8CU_REG_CTRL_B: rd_mux = ctrl_b_q;
    `T8CU_REG_COUNT: rd_mux = count_value_q;
    `T8CU_REG_CMP_A: rd_mux = pwm ? buf_a_q : compare_a_value_q;
    `T8CU_REG_CMP_B: rd_mux = pwm ? buf_b_q : compare_b_value_q;
    `T8CU_REG_MASK: rd_mux = {5'h00, mask_q};
    `T8CU_REG_FLAG: rd_mux = {5'h00, flag_q};
    `T8CU_REG_POWER: rd_mux = {7'h00, power_off_q};
    default: rd_mux = 8'h00;
  endcase
end

////////////////////////////////////////////////////////////////////////////
// avalon handshake: one wait cycle, then a single ready cycle
// a fixed latency keeps the slave simple at the cost of bus rate

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    wait_q <= 1'b1;
    rdata_q <= 32'h00000000;
  end else begin
    if ((avs_read | avs_write) && wait_q) begin
      wait_q <= 1'b0;
      if (avs_read)
        rdata_q <= {24'h000000, rd_mux};
    end else begin
      wait_q <= 1'b1;
    end
  end
end

assign avs_waitrequest = wait_q;
assign avs_readdata = rdata_q;
assign irq_overflow = irq_q[`T8CU_BIT_OVF];
assign irq_compare_a = irq_q[`T8CU_BIT_CMP_A];
assign irq_compare_b = irq_q[`T8CU_BIT_CMP_B];

endmodule

// [t8cu_top_monitor.sv]
// checker for the 8-bit timer: bus handshake, irq masking, pin override
// assumes the port list of t8cu_top; bound to it after the module
`include "t8cu_consts.vh"
module t8cu_mon (
  input wire clk,
  input wire reset_n,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire irq_overflow,
  input wire irq_compare_a,
  input wire irq_compare_b,
  input wire compare_output_a_drive,
  input wire compare_output_b_drive
);
  ////////////////////////////////////////////////////////////////
  // mirrors of mask and output mode, taken from accepted writes
  logic [2:0] mask_q;
  logic [3:0] com_q;
  wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_q <= 3'h0;
      com_q <= 4'h0;
    end else if (wr_ok && avs_address[5:2] == `T8CU_REG_MASK) begin
      mask_q <= avs_writedata[2:0];
    end else if (wr_ok && avs_address[5:2] == `T8CU_REG_CTRL_A) begin
      com_q <= avs_writedata[7:4];
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence req_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  wait_answer_a: assert property (req_s |=> !avs_waitrequest)
    else $error("request not answered after one cycle");
  wait_stand_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  read_width_a: assert property (
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data wider than eight bits");
  // irq is registered from flag and mask, so it sees the mask one late
  irq_ovf_mask_a: assert property (irq_overflow |-> $past(mask_q[0]))
    else $error("overflow irq while masked");
  irq_cmpa_mask_a: assert property (
    irq_compare_a |-> $past(mask_q[1]))
    else $error("compare a irq while masked");
  irq_cmpb_mask_a: assert property (
    irq_compare_b |-> $past(mask_q[2]))
    else $error("compare b irq while masked");
  drive_oca_a: assert property ($stable(com_q[3:2]) |->
    compare_output_a_drive == (com_q[3:2] != 2'h0))
    else $error("output a override wrong for its mode");
  drive_ocb_a: assert property ($stable(com_q[1:0]) |->
    compare_output_b_drive == (com_q[1:0] != 2'h0))
    else $error("output b override wrong for its mode");
endmodule

bind t8cu_top t8cu_mon t8cu_mon_inst (
  .clk(clk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .irq_overflow(irq_overflow), .irq_compare_a(irq_compare_a),
  .irq_compare_b(irq_compare_b),
  .compare_output_a_drive(compare_output_a_drive),
  .compare_output_b_drive(compare_output_b_drive)
);

// [t8cu_wave.v]
// waveform generator for one compare output
// assumes match already carries the tick and the write block
`include "t8cu_consts.vh"

module t8cu_wave (
  input wire clk,
  input wire reset_n,
  input wire tick,
  input wire match,
  input wire force_cmp,
  input wire pwm_fast,
  input wire pwm_pc,
  input wire down,
  input wire wrap,
  input wire tog_ok,
  input wire [1:0] com,
  output reg oc,
  output reg oc_drive
);

reg oc_d;
wire inv = (com == `T8CU_COM_SET);

always @* begin
  oc_d = oc;
  if (!pwm_fast && !pwm_pc) begin
    if (force_cmp || match) begin
      case (com)
        `T8CU_COM_TOGGLE: oc_d = ~oc;
        `T8CU_COM_CLEAR: oc_d = 1'b0;
        `T8CU_COM_SET: oc_d = 1'b1;
        default: oc_d = oc;
      endcase
    end
  end else if (tick) begin
    if (com == `T8CU_COM_TOGGLE) begin
      if (tog_ok && match)
        oc_d = ~oc;
    end else if (com != `T8CU_COM_NONE) begin
      // at wrap the restore wins, so a compare at max holds steady
      if (pwm_fast) begin
        if (wrap)
          oc_d = ~inv;
        else if (match)
          oc_d = inv;
      end else if (match) begin
        oc_d = down ? ~inv : inv;
      end
    end
  end
end

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    oc <= 1'b0;
    oc_drive <= 1'b0;
  end else begin
    oc <= oc_d;
    oc_drive <= (com != `T8CU_COM_NONE);
  end
end

endmodule

// [tb_top.sv]
// self-checking bench for the 8-bit timer with two compare units
// assumes t8cu_top with its bound checker; the bench drives every port
`include "t8cu_consts.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
$display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, avs_read, avs_write, external_count_pin;
  logic overflow_ack, compare_a_ack, compare_b_ack, e;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [7:0] q, r;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, irq_overflow, irq_compare_a, irq_compare_b;
  wire oca, oca_drv, ocb, ocb_drv;
  int n_mismatch, n_checks, n;
  logic [1:0] coms [4] = '{2'h3, 2'h2, 2'h1, 2'h1};

  t8cu_top t8cu_top_inst (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .external_count_pin(external_count_pin),
    .overflow_ack(overflow_ack), .compare_a_ack(compare_a_ack),
    .compare_b_ack(compare_b_ack), .irq_overflow(irq_overflow),
    .irq_compare_a(irq_compare_a), .irq_compare_b(irq_compare_b),
    .compare_output_a(oca), .compare_output_a_drive(oca_drv),
    .compare_output_b(ocb), .compare_output_b_drive(ocb_drv)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task end_sim;
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one bus access; holds the request until waitrequest is seen low
  task automatic acc(input logic w, input logic [3:0] i, input logic [7:0] d);
    int k = 0;
    @(posedge clk);
    avs_address <= {i, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (k >= 20) n_mismatch++;
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wr(input logic [3:0] i, input logic [7:0] d);
    acc(1'b1, i, d);
  endtask
  task rd(input logic [3:0] i, input logic [7:0] x);
    acc(1'b0, i, 8'h00);
    `CHK(q, x)
  endtask
  task cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  task ack(input logic [2:0] m);
    {compare_b_ack, compare_a_ack, overflow_ack} <= m;
    @(posedge clk);
    {compare_b_ack, compare_a_ack, overflow_ack} <= 3'h0;
  endtask
  // two reads three clocks apart: returns the earlier count in r
  task two_reads;
    acc(1'b0, `T8CU_REG_COUNT, 8'h00);
    r = q;
    acc(1'b0, `T8CU_REG_COUNT, 8'h00);
  endtask
  task pulses;
    repeat (3) begin
      external_count_pin <= 1'b1;
      cyc(6);
      external_count_pin <= 1'b0;
      cyc(6);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    n_mismatch++;
    end_sim;
  end
  initial begin
    n_mismatch = 0;
    n_checks = 0;
    reset_n = 1'b0;
    {avs_read, avs_write, external_count_pin} = 3'h0;
    {overflow_ack, compare_a_ack, compare_b_ack} = 3'h0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 9; i++) rd(i[3:0], 8'h00);
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00);
    wr(`T8CU_REG_COUNT, 8'h5a);
    rd(`T8CU_REG_COUNT, 8'h5a);
    avs_byteenable <= 4'h0;
    wr(`T8CU_REG_COUNT, 8'h77);
    avs_byteenable <= 4'h1;
    cyc(20);
    rd(`T8CU_REG_COUNT, 8'h5a);
    wr(`T8CU_REG_CTRL_B, 8'h01);
    two_reads;
    `CHK(q - r, 8'h03)
    // overflow in normal mode, compares parked out of reach
    wr(`T8CU_REG_CTRL_B, 8'h00);
    wr(`T8CU_REG_CMP_A, 8'h80);
    wr(`T8CU_REG_CMP_B, 8'h80);
    wr(`T8CU_REG_FLAG, 8'h07);
    wr(`T8CU_REG_MASK, 8'h01);
    wr(`T8CU_REG_COUNT, 8'hf0);
    wr(`T8CU_REG_CTRL_B, 8'h01);
    n = 0;
    while (irq_overflow !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    `CHK(irq_overflow, 1'b1)
    wr(`T8CU_REG_CTRL_B, 8'h00);
    rd(`T8CU_REG_FLAG, 8'h01);
    wr(`T8CU_REG_FLAG, 8'h00);
    rd(`T8CU_REG_FLAG, 8'h01);
    ack(3'h1);
    rd(`T8CU_REG_FLAG, 8'h00);
    `CHK(irq_overflow, 1'b0)
    // clear on match at compare a
    wr(`T8CU_REG_CMP_A, 8'h05);
    wr(`T8CU_REG_COUNT, 8'h00);
    wr(`T8CU_REG_CTRL_A, 8'h02);
    wr(`T8CU_REG_MASK, 8'h02);
    wr(`T8CU_REG_CTRL_B, 8'h01);
    repeat (6) begin
      acc(1'b0, `T8CU_REG_COUNT, 8'h00);
      `CHK(q <= 8'h05, 1'b1)
    end
    `CHK(irq_compare_a, 1'b1)
    wr(`T8CU_REG_CTRL_B, 8'h00);
    // the tick after a stop may still match; a set would beat the ack
    cyc(1);
    ack(3'h2);
    rd(`T8CU_REG_FLAG, 8'h00);
    // a count write equal to the compare value must not match
    wr(`T8CU_REG_CTRL_A, 8'h00);
    wr(`T8CU_REG_CMP_A, 8'h30);
    wr(`T8CU_REG_COUNT, 8'h30);
    wr(`T8CU_REG_CTRL_B, 8'h01);
    cyc(4);
    wr(`T8CU_REG_CTRL_B, 8'h00);
    rd(`T8CU_REG_FLAG, 8'h00);
    wr(`T8CU_REG_CMP_B, 8'h31);
    wr(`T8CU_REG_COUNT, 8'h2c);
    wr(`T8CU_REG_CTRL_B, 8'h01);
    cyc(10);
    wr(`T8CU_REG_CTRL_B, 8'h00);
    rd(`T8CU_REG_FLAG, 8'h06);
    `CHK(irq_compare_a, 1'b1)
    `CHK(irq_compare_b, 1'b0)
    wr(`T8CU_REG_MASK, 8'h04);
    cyc(2);
    `CHK(irq_compare_a, 1'b0)
    `CHK(irq_compare_b, 1'b1)
    ack(3'h4);
    wr(`T8CU_REG_FLAG, 8'h02);
    rd(`T8CU_REG_FLAG, 8'h00);
    // pwm: the new compare b sits in the buffer until top
    wr(`T8CU_REG_CTRL_A, 8'h03);
    wr(`T8CU_REG_CMP_B, 8'h10);
    rd(`T8CU_REG_CMP_B, 8'h10);
    wr(`T8CU_REG_COUNT, 8'h08);
    wr(`T8CU_REG_CTRL_B, 8'h01);
    cyc(12);
    wr(`T8CU_REG_CTRL_B, 8'h00);
    rd(`T8CU_REG_FLAG, 8'h00);
    // forced compare with set, clear and toggle
    acc(1'b0, `T8CU_REG_COUNT, 8'h00);
    r = q;
    e = 1'b0;
    for (int k = 0; k < 4; k++) begin
      wr(`T8CU_REG_CTRL_A, {coms[k], coms[k], 4'h0});
      wr(`T8CU_REG_CTRL_B, 8'hc0);
      e = (coms[k] == 2'h1) ? !e : coms[k][0];
      cyc(3);
      `CHK(oca, e)
      `CHK(ocb, e)
    end
    rd(`T8CU_REG_FLAG, 8'h00);
    rd(`T8CU_REG_COUNT, r);
    wr(`T8CU_REG_CTRL_A, 8'h53);
    wr(`T8CU_REG_CTRL_B, 8'hc0);
    cyc(3);
    `CHK(oca, e)
    // fast pwm on unit a: set at the wrap, cleared at the match
    wr(`T8CU_REG_CTRL_A, 8'h83);
    wr(`T8CU_REG_COUNT, 8'hfc);
    wr(`T8CU_REG_CTRL_B, 8'h01);
    cyc(16);
    `CHK(oca, 1'b1)
    cyc(48);
    `CHK(oca, 1'b0)
    wr(`T8CU_REG_CTRL_B, 8'h00);
    // power reduction holds the count
    wr(`T8CU_REG_CTRL_A, 8'h00);
    wr(`T8CU_REG_COUNT, 8'h40);
    wr(`T8CU_REG_POWER, 8'h01);
    wr(`T8CU_REG_CTRL_B, 8'h01);
    cyc(10);
    rd(`T8CU_REG_COUNT, 8'h40);
    wr(`T8CU_REG_POWER, 8'h00);
    two_reads;
    `CHK(q - r, 8'h03)
    // external pin, rising then falling edges
    wr(`T8CU_REG_CTRL_B, 8'h00);
    wr(`T8CU_REG_COUNT, 8'h00);
    wr(`T8CU_REG_CTRL_B, 8'h07);
    pulses;
    rd(`T8CU_REG_COUNT, 8'h03);
    wr(`T8CU_REG_CTRL_B, 8'h06);
    pulses;
    rd(`T8CU_REG_COUNT, 8'h06);
    // phase correct turns at max and counts down
    wr(`T8CU_REG_CTRL_A, 8'h01);
    wr(`T8CU_REG_COUNT, 8'h80);
    wr(`T8CU_REG_CTRL_B, 8'h01);
    cyc(200);
    two_reads;
    `CHK(r - q, 8'h03)
    end_sim;
  end
endmodule
